// *** pis_pkg.sv ***
// Purpose: shared constants for the second interrupt status/enable register block
// Assumes: 32-bit classic Wishbone slave, word-aligned registers
// Notes: printed register offsets are word indices; byte address is index times four
package pis_pkg;
    localparam int REG_W = 16;
    localparam int WB_DW = 32;
    localparam int WB_AW = 8;
    localparam int N_EVT = 8;
    localparam int IDX_W = 6;

    // register word indices
    localparam logic [7:0] IDX_INT_CTRL = 8'h11;
    localparam logic [7:0] IDX_INT_STATUS_TWO = 8'h13;

    // interrupt_status_two layout: flags in the high byte, enables in the low byte
    localparam int ST_FLAG_LSB = 8;
    localparam int ST_EN_LSB = 0;
    localparam logic [REG_W-1:0] STATUS_TWO_RESET = 16'h0000;

    // event positions within each byte
    localparam int EVT_JABBER = 0;
    localparam int EVT_POL_WAKE = 1;
    localparam int EVT_SLEEP = 2;
    localparam int EVT_MDIX = 3;
    localparam int EVT_LB_FIFO = 4;
    localparam int EVT_PAGE_RX = 5;
    localparam int EVT_AN_ERR = 6;
    localparam int EVT_EEE_ERR = 7;

    // interrupt control register bits
    localparam int CTRL_OUT_EN_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_TEST_BIT = 2;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h8;

    localparam logic [WB_DW-1:0] WB_ZERO = 32'h0000_0000;
endpackage : pis_pkg

// *** pis_flag_bank.sv ***
// Purpose: bank of latched-high event flags with clear-on-read
// Assumes: event inputs are levels synchronous to clock_i
// Notes: a set in the clearing cycle wins; only flags seen by the read are cleared
`timescale 1ns/1ps
`default_nettype none
module pis_flag_bank
    import pis_pkg::*;
#(
    parameter int N = N_EVT
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // events and clear
    input wire logic [N-1:0] event_i,
    input wire logic clear_i,
    input wire logic [N-1:0] clear_mask_i,
    // flags
    output logic [N-1:0] flag_o
);
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_flag
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                    flag_o[g] <= 1'b0;
                else
                    flag_o[g] <= event_i[g] | (flag_o[g] & ~(clear_i & clear_mask_i[g]));
            end
        end
    endgenerate
endmodule : pis_flag_bank
`default_nettype wire

// *** pis_pin_drive.sv ***
// Purpose: drives the shared interrupt / power-down pin
// Assumes: pin input is synchronous to clock_i
// Notes: pin is released and read as power-down request when the output is off
`timescale 1ns/1ps
`default_nettype none
module pis_pin_drive
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // control
    input wire logic irq_i,
    input wire logic out_en_i,
    input wire logic idle_high_i,
    // pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    // power-down request
    output logic powerdown_o
);
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end
        else
        begin
            pin_oe_o <= out_en_i;
            pin_o <= out_en_i & (idle_high_i ? ~irq_i : irq_i);
        end
    end

    // low level on the released pin requests power-down
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            powerdown_o <= 1'b0;
        else
            powerdown_o <= ~out_en_i & ~pin_i;
    end
endmodule : pis_pin_drive
`default_nettype wire

// *** pis_top.sv ***
// Purpose: second interrupt status and enable register with interrupt pin control
// Assumes: classic Wishbone slave, 20 MHz clock_i, event levels from detector logic
// Notes: one wait state; ack is high in the second cycle of a request
`timescale 1ns/1ps
`default_nettype none
module pis_top
    import pis_pkg::*;
#(
    parameter int N = N_EVT
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [WB_DW-1:0] wb_dat_i,
    output logic [WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // event conditions from the detectors
    input wire logic eee_err_i,
    input wire logic an_err_i,
    input wire logic page_rx_i,
    input wire logic lb_fifo_err_i,
    input wire logic mdix_change_i,
    input wire logic sleep_event_i,
    input wire logic pol_change_i,
    input wire logic wake_packet_i,
    input wire logic jabber_i,
    // irq_or_powerdown_pin
    input wire logic irq_or_powerdown_pin_i,
    output logic irq_or_powerdown_pin_o,
    output logic irq_or_powerdown_pin_oe_o,
    // status outputs
    output logic irq_o,
    output logic powerdown_o
);
    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic addr_hit(input logic [WB_AW-1:0] adr, input logic [7:0] idx);
        addr_hit = (adr[WB_AW-1:2] == idx[IDX_W-1:0]);
    endfunction : addr_hit

    logic req;
    logic hit_status;
    logic hit_ctrl;
    logic do_write;
    logic do_read_clear;

    assign req = wb_cyc_i & wb_stb_i;
    assign hit_status = addr_hit(wb_adr_i, IDX_INT_STATUS_TWO);
    assign hit_ctrl = addr_hit(wb_adr_i, IDX_INT_CTRL);
    // effects land at the edge where the master samples ack
    assign do_write = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign do_read_clear = req & wb_ack_o & ~wb_we_i & hit_status;

    ////////////////////////////////////////////////////////////////////////////
    // event gathering

    logic [N-1:0] event_vec;
    logic [N-1:0] flag;
    logic [N-1:0] read_snap_r;

    always_comb
    begin
        event_vec = '0;
        event_vec[EVT_EEE_ERR] = eee_err_i;
        event_vec[EVT_AN_ERR] = an_err_i;
        event_vec[EVT_PAGE_RX] = page_rx_i;
        event_vec[EVT_LB_FIFO] = lb_fifo_err_i;
        event_vec[EVT_MDIX] = mdix_change_i;
        event_vec[EVT_SLEEP] = sleep_event_i;
        event_vec[EVT_POL_WAKE] = pol_change_i | wake_packet_i;
        event_vec[EVT_JABBER] = jabber_i;
    end

    pis_flag_bank #(
        .N(N)
    ) u_flags (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .event_i(event_vec),
        .clear_i(do_read_clear),
        .clear_mask_i(read_snap_r),
        .flag_o(flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // enable register

    logic [N-1:0] enable_r;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            enable_r <= STATUS_TWO_RESET[ST_EN_LSB +: N];
        else if (do_write & hit_status)
            enable_r <= wb_dat_i[ST_EN_LSB +: N];
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt control register

    logic [CTRL_W-1:0] ctrl_r;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            ctrl_r <= CTRL_RESET;
        else if (do_write & hit_ctrl)
            ctrl_r <= wb_dat_i[CTRL_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and acknowledge

    logic [REG_W-1:0] status_view;
    logic [WB_DW-1:0] rdata;

    always_comb
    begin
        status_view = '0;
        status_view[ST_FLAG_LSB +: N] = flag;
        status_view[ST_EN_LSB +: N] = enable_r;
    end

    always_comb
    begin
        rdata = WB_ZERO;
        if (hit_status)
            rdata[REG_W-1:0] = status_view;
        else if (hit_ctrl)
            rdata[CTRL_W-1:0] = ctrl_r;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req & ~wb_ack_o;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            wb_dat_o <= WB_ZERO;
        else if (req & ~wb_ack_o & ~wb_we_i)
            wb_dat_o <= rdata;
        else if (~req)
            wb_dat_o <= WB_ZERO;
    end

    // flags shown to software; only these may be cleared by the read
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            read_snap_r <= '0;
        else if (req & ~wb_ack_o & ~wb_we_i & hit_status)
            read_snap_r <= flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt generation

    logic irq_req;

    assign irq_req = ctrl_r[CTRL_TEST_BIT]
        | (ctrl_r[CTRL_MASTER_BIT] & |(flag & enable_r));

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= irq_req;
    end

    pis_pin_drive u_pin (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .irq_i(irq_req),
        .out_en_i(ctrl_r[CTRL_OUT_EN_BIT]),
        .idle_high_i(ctrl_r[CTRL_POL_BIT]),
        .pin_i(irq_or_powerdown_pin_i),
        .pin_o(irq_or_powerdown_pin_o),
        .pin_oe_o(irq_or_powerdown_pin_oe_o),
        .powerdown_o(powerdown_o)
    );
endmodule : pis_top
`default_nettype wire

// *** pis_props.sv ***
// Purpose: checker for the second interrupt status block
// Assumes: legal single-cycle Wishbone master
// Notes: shadows enables and control from bus writes
`timescale 1ns/1ps
`default_nettype none
module pis_props
    import pis_pkg::*;
(
    // clock and bus
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [WB_DW-1:0] wb_dat_i,
    input wire logic [WB_DW-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // events and pin
    input wire logic jabber_i,
    input wire logic irq_or_powerdown_pin_i,
    input wire logic irq_or_powerdown_pin_o,
    input wire logic irq_or_powerdown_pin_oe_o,
    input wire logic irq_o,
    input wire logic powerdown_o
);
    logic [7:0] en_r;
    logic [3:0] ctl_r;
    logic wr_hit;
    logic [5:0] idx;
    assign idx = wb_adr_i[7:2];
    assign wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            en_r <= 8'h00;
            ctl_r <= 4'h8;
        end
        else if (wr_hit && idx == IDX_INT_STATUS_TWO[5:0])
            en_r <= wb_dat_i[7:0];
        else if (wr_hit && idx == IDX_INT_CTRL[5:0])
            ctl_r <= wb_dat_i[3:0];
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_rd; wb_ack_o && !wb_we_i; endsequence
    sequence s_ctl_hold; $stable(ctl_r) && !wr_hit; endsequence
    a_ack_one_wait: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    // read data is zeroed at the edge after ack, so it is seen one edge later
    a_dat_idle: assert property (wb_ack_o |=> ##1 wb_dat_o == WB_ZERO) else $error("dat not zero");
    a_en_readback: assert property (s_rd and idx == IDX_INT_STATUS_TWO[5:0] |->
        wb_dat_o[31:16] == 16'h0000 && wb_dat_o[7:0] == en_r) else $error("enable readback");
    a_ctl_readback: assert property (s_rd and idx == IDX_INT_CTRL[5:0] |->
        wb_dat_o == {28'h0, ctl_r}) else $error("control readback");
    a_test_irq: assert property (ctl_r[2] |=> irq_o) else $error("test irq missing");
    a_master_gate: assert property (!ctl_r[1] && !ctl_r[2] |=> !irq_o) else $error("irq leak");
    a_jab_irq: assert property (jabber_i && en_r[0] && ctl_r[1] |-> ##2 irq_o)
        else $error("jabber irq missing");
    a_pin_drive: assert property (ctl_r[0] ##0 s_ctl_hold |=> irq_or_powerdown_pin_oe_o
        && irq_or_powerdown_pin_o == (irq_o ^ ctl_r[3])) else $error("pin drive");
    a_pd_input: assert property (!ctl_r[0] && !irq_or_powerdown_pin_i ##0 s_ctl_hold
        |=> powerdown_o && !irq_or_powerdown_pin_oe_o) else $error("power-down input");
endmodule : pis_props
bind pis_top pis_props u_props (.*);
`default_nettype wire

// *** pis_host_model.sv ***
// Purpose: host side of the shared interrupt / power-down pin
// Assumes: pin has an external pull-up
// Notes: host pulls the pin low to request power-down
`timescale 1ns/1ps
`default_nettype none
module pis_host_model
(
    // pin drive from the device
    input wire logic pin_i,
    input wire logic pin_oe_i,
    // host power-down request
    input wire logic pd_req_i,
    // resolved pin level
    output logic level_o
);
    // released pin sits at the pull-up level unless the host pulls it low for power-down
    assign level_o = pin_oe_i ? pin_i : !pd_req_i;
endmodule : pis_host_model
`default_nettype wire

// *** pis_top_tb.sv ***
// Purpose: register and interrupt tests of the status block
// Assumes: one wait state bus, registered interrupt outputs
// Notes: expected values built from the register layout
`timescale 1ns/1ps
`default_nettype none
module pis_top_tb;
    logic clock_i, rst_i, cyc, stb, we, ack, irq, pd, lvl, pin_o, pin_oe, pd_req;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, rdat;
    logic [8:0] ev;
    int error_cnt, samples_checked, cycles, k;
    pis_top DUT (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .eee_err_i(ev[8]), .an_err_i(ev[7]), .page_rx_i(ev[6]),
        .lb_fifo_err_i(ev[5]), .mdix_change_i(ev[4]), .sleep_event_i(ev[3]),
        .pol_change_i(ev[2]), .wake_packet_i(ev[1]), .jabber_i(ev[0]),
        .irq_or_powerdown_pin_i(lvl), .irq_or_powerdown_pin_o(pin_o),
        .irq_or_powerdown_pin_oe_o(pin_oe), .irq_o(irq), .powerdown_o(pd));
    pis_host_model u_host (.pin_i(pin_o), .pin_oe_i(pin_oe), .pd_req_i(pd_req), .level_o(lvl));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        @(posedge clock_i);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clock_i);
            n++;
        end
        // read data is taken at the edge where ack is seen
        rdat = dat_o;
        if (n == 20)
            chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock_i);
    endtask : xfer
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rd
    task automatic pulse(input int i);
        ev <= 9'h001 << i;
        @(posedge clock_i);
        ev <= 9'h000;
        repeat (3) @(posedge clock_i);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, pd_req, adr, sel, dat, ev} = '0;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd("status", 8'h4C, 32'h0);
        rd("control", 8'h44, 32'h8);
        rd("unmapped", 8'h40, 32'h0);
        xfer(1'b1, 8'h4C, 32'hFFFF_FFFF);
        rd("enables", 8'h4C, 32'hFF);
        for (k = 0; k < 9; k++)
        begin
            pulse(k);
            rd("flag", 8'h4C, 32'hFF | (32'h100 << ((k < 2) ? k : k - 1)));
            rd("cleared", 8'h4C, 32'hFF);
        end
        xfer(1'b1, 8'h44, 32'hB);
        xfer(1'b1, 8'h4C, 32'h1);
        pulse(3);
        chk("masked irq", 32'h0, irq);
        pulse(0);
        chk("irq", 32'h1, irq);
        chk("pin", 32'h2, {pin_oe, pin_o});
        rd("status", 8'h4C, 32'h501);
        @(posedge clock_i);
        chk("irq clear", 32'h0, irq);
        xfer(1'b1, 8'h44, 32'h3);
        pulse(0);
        chk("pin", 32'h3, {pin_oe, pin_o});
        rd("status", 8'h4C, 32'h101);
        xfer(1'b1, 8'h44, 32'h4);
        pd_req <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("test irq", 32'h1, irq);
        chk("power-down", 32'h1, {pin_oe, pd});
        pd_req <= 1'b0;
        xfer(1'b1, 8'h44, 32'h0);
        @(posedge clock_i);
        chk("test off", 32'h0, irq);
        ev <= 9'h001;
        @(posedge clock_i);
        rd("held", 8'h4C, 32'h101);
        rd("held", 8'h4C, 32'h101);
        ev <= 9'h000;
        @(posedge clock_i);
        rd("released", 8'h4C, 32'h101);
        rd("released", 8'h4C, 32'h1);
        complete_run();
    end
endmodule : pis_top_tb
`default_nettype wire
